//--- rtl/ast_pkg.sv
package ast_pkg;
   localparam int          NUM_CHAN       = 12;
   localparam int          NUM_TRIG       = 8;
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 32;
   // register offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STATUS     = 8'h04;
   // sequence_a_control field positions
   localparam int          CHAN_LSB       = 0;
   localparam int          CHAN_MSB       = 11;
   localparam int          TSEL_LSB       = 12;
   localparam int          TSEL_MSB       = 14;
   localparam int          POL_BIT        = 18;
   localparam int          SKIP_BIT       = 19;
   localparam int          START_BIT      = 26;
   localparam int          ENABLE_BIT     = 31;
   // status field positions
   localparam int          ST_BUSY_BIT    = 0;
   localparam int          ST_CHAN_LSB    = 4;
   localparam int          ST_CHAN_MSB    = 7;
   // reset values
   localparam logic [11:0] RST_CHAN       = 12'h000;
   localparam logic [2:0]  RST_TSEL       = 3'h0;
   localparam logic        RST_POL        = 1'b0;
   localparam logic        RST_SKIP       = 1'b0;
   // timing: a launch pulse lasts at least one system clock period
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          MIN_PULSE_NS   = 10;
   localparam int          MIN_PULSE_CYC  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_REQ,
      SEQ_WAIT
   } ast_seq_e;
endpackage

//--- rtl/ast_trig_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ast_trig_if;
   logic [7:0] trig;
   logic       seq_busy;
   modport device (input trig, output seq_busy);
   modport source (output trig, input seq_busy);
endinterface
`default_nettype wire

//--- rtl/ast_seq_ctrl.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ast_seq_ctrl
   import ast_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   // trigger link
   ast_trig_if.device             link,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // sequence mode inputs
   input  wire logic              seq_enable,
   input  wire logic              cont_mode,
   // converter side
   output logic                   conv_req,
   output logic      [3:0]        conv_chan,
   input  wire logic              conv_done
);
   logic [11:0]       chan_mask_r, chan_mask_nxt;
   logic [2:0]        trig_sel_r, trig_sel_nxt;
   logic              edge_pol_r, edge_pol_nxt;
   logic              sync_skip_r, sync_skip_nxt;
   logic              sw_launch_r, sw_launch_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [7:0]        s1_r, s2_r, s3_r, filt_r;
   logic [7:0]        s1_nxt, s2_nxt, s3_nxt, filt_nxt;
   logic              prev_sync_r, prev_sync_nxt;
   logic              prev_raw_r, prev_raw_nxt;
   logic              hw_edge;
   ast_seq_e          state_r, state_nxt;
   logic [3:0]        chan_r, chan_nxt;
   logic              req_r, req_nxt;
   logic              busy_r, busy_nxt;
   logic              launch;
   logic [4:0]        first_hit, next_hit;

   // returns {found, index} of the lowest set mask bit at or above 'from'
   function automatic logic [4:0] find_from(input logic [11:0] m, input logic [4:0] from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NUM_CHAN - 1; i >= 0; i--) begin
         if (m[i] && (5'(i) >= from)) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // register file
   always_comb begin
      chan_mask_nxt = chan_mask_r;
      trig_sel_nxt  = trig_sel_r;
      edge_pol_nxt  = edge_pol_r;
      sync_skip_nxt = sync_skip_r;
      sw_launch_nxt = 1'b0;
      rdata_nxt     = '0;
      if (reg_wr) begin
         if (reg_addr == OFS_CTRL) begin
            // the mask is frozen while enabled; a write beside a low enable lands
            if (!seq_enable) begin
               chan_mask_nxt = reg_wdata[CHAN_MSB:CHAN_LSB];
            end
            // trigger setup is taken at any time; keeping it steady is up to software
            trig_sel_nxt  = reg_wdata[TSEL_MSB:TSEL_LSB];
            edge_pol_nxt  = reg_wdata[POL_BIT];
            sync_skip_nxt = reg_wdata[SKIP_BIT];
            sw_launch_nxt = reg_wdata[START_BIT];
         end
      end
      if (reg_rd) begin
         if (reg_addr == OFS_CTRL) begin
            rdata_nxt[CHAN_MSB:CHAN_LSB] = chan_mask_r;
            rdata_nxt[TSEL_MSB:TSEL_LSB] = trig_sel_r;
            rdata_nxt[POL_BIT]           = edge_pol_r;
            rdata_nxt[SKIP_BIT]          = sync_skip_r;
            rdata_nxt[ENABLE_BIT]        = seq_enable;
            // launch bit and unused ranges read as zero
         end else if (reg_addr == OFS_STATUS) begin
            rdata_nxt[ST_BUSY_BIT]             = busy_r;
            rdata_nxt[ST_CHAN_MSB:ST_CHAN_LSB] = chan_r;
         end else begin
            rdata_nxt = '0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         chan_mask_r <= RST_CHAN;
         trig_sel_r  <= RST_TSEL;
         edge_pol_r  <= RST_POL;
         sync_skip_r <= RST_SKIP;
         sw_launch_r <= 1'b0;
         rdata_r     <= '0;
      end else begin
         chan_mask_r <= chan_mask_nxt;
         trig_sel_r  <= trig_sel_nxt;
         edge_pol_r  <= edge_pol_nxt;
         sync_skip_r <= sync_skip_nxt;
         sw_launch_r <= sw_launch_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   // trigger path: three stages, a change counts once stages two and three agree
   always_comb begin
      s1_nxt = link.trig;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      filt_nxt = filt_r;
      for (int i = 0; i < NUM_TRIG; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            filt_nxt[i] = s3_r[i];
         end
      end
      prev_sync_nxt = filt_r[trig_sel_r];
      // bypass samples the raw pin; only safe for sources meeting the pulse width
      prev_raw_nxt  = link.trig[trig_sel_r];
      hw_edge = 1'b0;
      if (sync_skip_r) begin
         hw_edge = edge_pol_r ? (link.trig[trig_sel_r] && !prev_raw_r)
                              : (!link.trig[trig_sel_r] && prev_raw_r);
      end else begin
         hw_edge = edge_pol_r ? (filt_r[trig_sel_r] && !prev_sync_r)
                              : (!filt_r[trig_sel_r] && prev_sync_r);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s1_r        <= '0;
         s2_r        <= '0;
         s3_r        <= '0;
         filt_r      <= '0;
         prev_sync_r <= 1'b0;
         prev_raw_r  <= 1'b0;
      end else begin
         s1_r        <= s1_nxt;
         s2_r        <= s2_nxt;
         s3_r        <= s3_nxt;
         filt_r      <= filt_nxt;
         prev_sync_r <= prev_sync_nxt;
         prev_raw_r  <= prev_raw_nxt;
      end
   end

   // sequencer
   always_comb begin
      // the launch bit counts only while enabled and outside continuous mode; hardware edges count whenever enabled
      launch    = seq_enable && ((sw_launch_r && !cont_mode) || hw_edge || cont_mode);
      first_hit = find_from(chan_mask_r, 5'h00);
      next_hit  = find_from(chan_mask_r, {1'b0, chan_r} + 5'h01);
      state_nxt = state_r;
      chan_nxt  = chan_r;
      req_nxt   = 1'b0;
      busy_nxt  = 1'b1;
      case (state_r)
         SEQ_IDLE: begin
            busy_nxt = 1'b0;
            if (launch && first_hit[4]) begin
               chan_nxt  = first_hit[3:0];
               req_nxt   = 1'b1;
               busy_nxt  = 1'b1;
               state_nxt = SEQ_REQ;
            end
         end
         SEQ_REQ: begin
            state_nxt = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (!seq_enable) begin
               // disabling abandons the pass; the converter result is dropped
               busy_nxt  = 1'b0;
               state_nxt = SEQ_IDLE;
            end else if (conv_done) begin
               if (next_hit[4]) begin
                  chan_nxt  = next_hit[3:0];
                  req_nxt   = 1'b1;
                  state_nxt = SEQ_REQ;
               end else if (cont_mode && first_hit[4]) begin
                  chan_nxt  = first_hit[3:0];
                  req_nxt   = 1'b1;
                  state_nxt = SEQ_REQ;
               end else begin
                  busy_nxt  = 1'b0;
                  state_nxt = SEQ_IDLE;
               end
            end
         end
         default: begin
            busy_nxt  = 1'b0;
            state_nxt = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= SEQ_IDLE;
         chan_r  <= 4'h0;
         req_r   <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         chan_r  <= chan_nxt;
         req_r   <= req_nxt;
         busy_r  <= busy_nxt;
      end
   end

   assign reg_rdata     = rdata_r;
   assign conv_req      = req_r;
   assign conv_chan     = chan_r;
   assign link.seq_busy = busy_r;
endmodule
`default_nettype wire

//--- rtl/ast_trig_src.sv
`timescale 1ns/100ps
`default_nettype none
module ast_trig_src
   import ast_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // trigger link
   ast_trig_if.source      link,
   // user side
   input  wire logic       fire,
   input  wire logic [2:0] fire_sel,
   input  wire logic [7:0] fire_len,
   input  wire logic [7:0] idle_level,
   output logic            fire_busy,
   output logic            seq_busy_seen
);
   logic [7:0] trig_r, trig_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic       busy_r, busy_nxt;
   logic       seen_r, seen_nxt;
   logic [7:0] len_eff;

   always_comb begin
      // pulses shorter than the minimum are stretched to one cycle; the bypass path sees them, the synced filter needs two
      len_eff  = (fire_len < 8'(MIN_PULSE_CYC)) ? 8'(MIN_PULSE_CYC) : fire_len;
      trig_nxt = trig_r;
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      seen_nxt = link.seq_busy;
      if (!busy_r) begin
         trig_nxt = idle_level;
         if (fire) begin
            trig_nxt[fire_sel] = !idle_level[fire_sel];
            cnt_nxt  = len_eff - 8'h01;
            busy_nxt = 1'b1;
         end
      end else if (cnt_r == 8'h00) begin
         trig_nxt = idle_level;
         busy_nxt = 1'b0;
      end else begin
         cnt_nxt = cnt_r - 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         trig_r <= '0;
         cnt_r  <= 8'h00;
         busy_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         trig_r <= trig_nxt;
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         seen_r <= seen_nxt;
      end
   end

   assign link.trig     = trig_r;
   assign fire_busy     = busy_r;
   assign seq_busy_seen = seen_r;
endmodule
`default_nettype wire

//--- verification/ast_seq_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ast_seq_properties
   import ast_pkg::*;
(
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rstn,
   // trigger link
   input wire logic [7:0]        trig,
   input wire logic              seq_busy,
   // controller ports
   input wire logic              seq_enable,
   input wire logic              cont_mode,
   input wire logic              conv_req,
   input wire logic [3:0]        conv_chan,
   input wire logic              conv_done,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [3:0] last_r;
   logic [3:0] last_nxt;
   always_comb begin
      last_nxt = conv_req ? conv_chan : last_r;
   end
   always_ff @(posedge ref_clk) begin
      last_r <= rstn ? last_nxt : 4'h0;
   end
   req_pulse_a: assert property (conv_req |=> !conv_req)
      else $error("conv_req held past one cycle");
   req_busy_a: assert property (conv_req |-> seq_busy)
      else $error("conv_req outside a pass");
   chan_range_a: assert property (conv_req |-> conv_chan < NUM_CHAN)
      else $error("conv_chan beyond last channel");
   // a restart in continuous mode goes back down, so only plain passes count
   chan_ascend_a: assert property (conv_req && $past(seq_busy) && !$past(cont_mode)
      && !$past(cont_mode, 2) |-> conv_chan > last_r) else $error("channels not ascending");
   done_next_a: assert property (conv_done && seq_busy && !conv_req
      |=> conv_req || !seq_busy) else $error("no step after conv_done");
   off_quiet_a: assert property ((!seq_enable)[*4] |-> !conv_req && !seq_busy)
      else $error("activity while disabled");
   busy_end_a: assert property ($fell(seq_busy) |-> $past(conv_done) || !$past(seq_enable))
      else $error("pass ended without done");
   launch_zero_a: assert property (reg_rdata[START_BIT] == 1'h0)
      else $error("launch bit read as one");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside read cycle");
   cover property (conv_req && cont_mode);
   cover property ($fell(seq_busy));
   cover property (reg_rd ##1 reg_rdata != '0);
   cover property ($changed(trig) ##[1:8] conv_req);
endmodule
`default_nettype wire

//--- verification/tb_adc_sequence_trigger_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adc_sequence_trigger_control
   import ast_pkg::*;
;
   logic              ref_clk = '0, rstn = '0, reg_wr = '0, reg_rd = '0;
   logic              seq_enable = '0, cont_mode = '0, conv_done = '0, fire = '0;
   logic              conv_req;
   logic              fire_busy, seq_busy_seen;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic [DATA_W-1:0] reg_rdata;
   logic [3:0]        conv_chan;
   logic [2:0]        fire_sel = '0;
   logic [7:0]        fire_len = 8'h01;
   logic [7:0]        idle_level = 8'h00;
   logic [3:0]        got_q[$];
   int                fails = 0, comparisons = 0, dly = 0;
   ast_trig_if link ();
   ast_seq_ctrl ast_seq_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .seq_enable(seq_enable), .cont_mode(cont_mode), .conv_req(conv_req), .conv_chan(conv_chan),
      .conv_done(conv_done));
   ast_trig_src ast_trig_src_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link), .fire(fire),
      .fire_sel(fire_sel), .fire_len(fire_len), .idle_level(idle_level), .fire_busy(fire_busy),
      .seq_busy_seen(seq_busy_seen));
   ast_seq_properties ast_seq_properties_inst (.ref_clk(ref_clk), .rstn(rstn), .trig(link.trig),
      .seq_busy(link.seq_busy), .seq_enable(seq_enable), .cont_mode(cont_mode),
      .conv_req(conv_req), .conv_chan(conv_chan), .conv_done(conv_done), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // converter stand-in: every request answered a few cycles later
   always @(posedge ref_clk) begin
      conv_done <= (dly == 1);
      dly <= (conv_req === 1'h1) ? 3 : ((dly > 0) ? dly - 1 : 0);
      if (conv_req === 1'h1) got_q.push_back(conv_chan);
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= '1;
      @(posedge ref_clk);
      reg_wr <= '0;
      // step off the edge so a following call never drives the strobe twice in one time step
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= '1;
      @(posedge ref_clk);
      reg_rd <= '0;
      #1;
      chk("reg_rdata", e, reg_rdata & m);
   endtask
   // trigger setup only changes while the sequence is off, then it is switched on
   task cfg(input logic [31:0] d);
      seq_enable <= '0;
      wr(OFS_CTRL, d);
      seq_enable <= '1;
   endtask
   task wait_idle();
      int i;
      for (i = 0; i < 300 && (i < 4 || link.seq_busy !== 1'h0); i++) @(posedge ref_clk);
   endtask
   task automatic cmp_pass(input logic [11:0] m);
      logic [3:0] e[$];
      wait_idle();
      for (int n = 0; n < NUM_CHAN; n++) if (m[n]) e.push_back(4'(n));
      chk("pass length", e.size(), got_q.size());
      foreach (e[k]) if (k < got_q.size()) chk("conv_chan", e[k], got_q[k]);
      got_q = {};
   endtask
   task fire_at(input logic [2:0] s, input logic [7:0] l, output int lat);
      fire_sel <= s;
      fire_len <= l;
      fire <= '1;
      @(posedge ref_clk);
      fire <= '0;
      #1;
      chk("fire_busy", 1, fire_busy);
      for (lat = 1; lat < 40; lat++) begin
         @(posedge ref_clk);
         #1;
         if (conv_req === 1'h1) break;
      end
   endtask
   task t_regs();
      rd(OFS_CTRL, '1, '0);
      wr(OFS_CTRL, 32'h040c_5a5c);
      rd(OFS_CTRL, 32'h840c_7fff, 32'h000c_5a5c);
      rd(8'h08, '1, '0);
      chk("stray pass", 0, got_q.size());
      $display("test registers done");
   endtask
   task t_launch();
      wr(OFS_CTRL, 32'h0000_0805);
      seq_enable <= '1;
      wr(OFS_CTRL, 32'h0400_0a05);
      wr(OFS_CTRL, 32'h0400_0805);
      cmp_pass(12'h805);
      rd(OFS_CTRL, 32'h8400_0fff, 32'h8000_0805);
      rd(OFS_STATUS, 32'h0000_00ff, 32'h0000_00b0);
      $display("test software launch done");
   endtask
   task t_hw();
      int a, b;
      cfg(32'h000c_3001);
      fire_at(3'h3, 8'h02, a);
      chk("bypass latency", 1, a);
      rd(OFS_STATUS, 32'h0000_00ff, 32'h0000_0001);
      chk("seq_busy_seen", 1, seq_busy_seen);
      cmp_pass(12'h001);
      cfg(32'h0004_3001);
      fire_at(3'h3, 8'h02, b);
      chk("synced slower", 1, b > a);
      cmp_pass(12'h001);
      cfg(32'h0000_3001);
      fire_at(3'h3, 8'h0c, b);
      chk("falling edge launch", 1, b > 12);
      cmp_pass(12'h001);
      fire_at(3'h2, 8'h02, b);
      cmp_pass(12'h000);
      seq_enable <= '0;
      fire_at(3'h3, 8'h02, b);
      cmp_pass(12'h000);
      $display("test hardware trigger done");
   endtask
   task t_cont();
      cfg(32'h0000_00a0);
      // passes restart on their own, so the launch bit stays untouched here
      cont_mode <= '1;
      for (int i = 0; i < 300 && got_q.size() < 6; i++) @(posedge ref_clk);
      cont_mode <= '0;
      wait_idle();
      chk("whole passes", 0, got_q.size() % 2);
      chk("repeated", 1, got_q.size() >= 6);
      foreach (got_q[k]) chk("conv_chan", (k % 2) ? 7 : 5, got_q[k]);
      got_q = {};
      $display("test continuous mode done");
   endtask
   task final_report();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= '1;
      repeat (8) @(posedge ref_clk);
      t_regs();
      t_launch();
      t_hw();
      t_cont();
      final_report();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      final_report();
   end
endmodule
`default_nettype wire
